// File: gdi_device.sv
`timescale 1ns/1ps
`default_nettype none
module gdi_device (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Address strap, caught during reset
    input wire logic [4:0] i_addr,
    // Bus lines sensed, active low
    input wire logic [7:0] i_dio_n,
    input wire logic i_dav_n,
    input wire logic i_nrfd_n,
    input wire logic i_ndac_n,
    input wire logic i_atn_n,
    input wire logic i_eoi_n,
    input wire logic i_ifc_n,
    input wire logic i_ren_n,
    // Open-collector bus drive, enable low pulls the line low
    output logic [7:0] o_dio_n,
    output logic [7:0] o_dio_oe_n,
    output logic o_dav_n,
    output logic o_dav_oe_n,
    output logic o_nrfd_n,
    output logic o_nrfd_oe_n,
    output logic o_ndac_n,
    output logic o_ndac_oe_n,
    output logic o_eoi_n,
    output logic o_eoi_oe_n,
    output logic o_srq_n,
    output logic o_srq_oe_n,
    // Talk data from the instrument
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    input wire logic i_tx_last,
    output logic o_tx_ready,
    // Listen data to the instrument
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_rx_end,
    input wire logic i_rx_ready,
    // Service request and status
    input wire logic [7:0] i_status,
    input wire logic i_srq_req,
    output logic o_srq_pending,
    output logic o_spoll_read,
    // Interface state and events
    output logic o_talker,
    output logic o_listener,
    output logic o_spoll_mode,
    output logic o_remote,
    output logic o_lockout,
    output logic o_dev_clear,
    output logic o_trigger
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; lines turned active high before the first stage

    wire [gdi_pkg::PIN_W-1:0] pins_raw = {~i_dio_n, ~i_dav_n, ~i_nrfd_n, ~i_ndac_n,
                                          ~i_atn_n, ~i_eoi_n, ~i_ifc_n, ~i_ren_n};
    logic [gdi_pkg::PIN_W-1:0] sync1_r;
    logic [gdi_pkg::PIN_W-1:0] sync2_r;

    genvar gi;
    generate
        for (gi = 0; gi < gdi_pkg::PIN_W; gi++) begin : g_sync
            always_ff @(posedge i_ref_clk) begin
                if (i_rst) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= pins_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    wire ren_s = sync2_r[gdi_pkg::P_REN];
    wire ifc_s = sync2_r[gdi_pkg::P_IFC];
    wire eoi_s = sync2_r[gdi_pkg::P_EOI];
    wire atn_s = sync2_r[gdi_pkg::P_ATN];
    wire ndac_s = sync2_r[gdi_pkg::P_NDAC];
    wire nrfd_s = sync2_r[gdi_pkg::P_NRFD];
    wire dav_s = sync2_r[gdi_pkg::P_DAV];
    wire [7:0] dio_s = sync2_r[gdi_pkg::P_DIO +: 8];

    ////////////////////////////////////////////////////////////////////////////
    // Own address; a strap is only caught while reset is held

    logic [4:0] addr_r;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) addr_r <= i_addr;
    end
    // The reserved all-ones setting makes the device answer no address
    wire addr_ok = (addr_r != gdi_pkg::ADDR_RESERVED);

    ////////////////////////////////////////////////////////////////////////////
    // Acceptor handshake

    logic listen_r;
    logic [7:0] ah_byte;
    logic ah_stb;
    logic ah_nrfd_hold;
    logic ah_ndac_hold;
    // Commands are always taken unless IFC stands; data only while listening, paced by the user
    wire ah_active = (atn_s || listen_r) && !ifc_s;
    wire ah_ready = atn_s || i_rx_ready;

    gdi_acceptor u_acceptor (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_active(ah_active),
        .i_ready(ah_ready),
        .i_dav(dav_s),
        .i_data(dio_s),
        .o_nrfd_hold(ah_nrfd_hold),
        .o_ndac_hold(ah_ndac_hold),
        .o_byte(ah_byte),
        .o_byte_stb(ah_stb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command decode; the strobe is taken as a command if ATN still stands

    wire cmd_stb = ah_stb && atn_s;
    wire [6:0] code = ah_byte[6:0];
    wire [1:0] grp = code[gdi_pkg::GRP_MSB:gdi_pkg::GRP_LSB];
    wire own = addr_ok && (code[4:0] == addr_r);
    // Secondary group never matches, so no extended addressing
    wire is_mla = (grp == gdi_pkg::GRP_LISTEN) && own;
    wire is_mta = (grp == gdi_pkg::GRP_TALK) && own;
    wire is_unl = (code == gdi_pkg::CMD_UNL);
    wire is_unt = (code == gdi_pkg::CMD_UNT);
    wire c_mla = cmd_stb && is_mla;
    wire c_mta = cmd_stb && is_mta;
    wire c_gtl = cmd_stb && (code == gdi_pkg::CMD_GTL) && listen_r;
    wire c_sdc = cmd_stb && (code == gdi_pkg::CMD_SDC) && listen_r;
    wire c_dcl = cmd_stb && (code == gdi_pkg::CMD_DCL);
    wire c_get = cmd_stb && (code == gdi_pkg::CMD_GET);
    wire c_llo = cmd_stb && (code == gdi_pkg::CMD_LLO);
    wire c_spe = cmd_stb && (code == gdi_pkg::CMD_SPE);
    wire c_spd = cmd_stb && (code == gdi_pkg::CMD_SPD);

    ////////////////////////////////////////////////////////////////////////////
    // Talker, listener and serial poll state

    logic talk_r;
    logic spe_r;
    logic talk_nxt;
    logic listen_nxt;
    logic spe_nxt;

    // Other devices' addresses, the controller's among them, fall through
    always_comb begin
        talk_nxt = talk_r;
        listen_nxt = listen_r;
        spe_nxt = spe_r;
        if (ifc_s) begin
            talk_nxt = 1'b0;
            listen_nxt = 1'b0;
            spe_nxt = 1'b0;
        end else begin
            if (c_mta) talk_nxt = 1'b1;
            else if (c_mla || (cmd_stb && is_unt)) talk_nxt = 1'b0;
            if (c_mla) listen_nxt = 1'b1;
            else if (c_mta || (cmd_stb && is_unl)) listen_nxt = 1'b0;
            if (c_spe) spe_nxt = 1'b1;
            else if (c_spd) spe_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            talk_r <= 1'b0;
            listen_r <= 1'b0;
            spe_r <= 1'b0;
        end else begin
            talk_r <= talk_nxt;
            listen_r <= listen_nxt;
            spe_r <= spe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Remote and local lockout; IFC leaves both untouched

    logic remote_r;
    logic lockout_r;
    // REN alone does not enter remote; the next own listen address does
    wire remote_nxt = ren_s && (c_mla || (remote_r && !c_gtl));
    wire lockout_nxt = ren_s && (c_llo || lockout_r);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            remote_r <= 1'b0;
            lockout_r <= 1'b0;
        end else begin
            remote_r <= remote_nxt;
            lockout_r <= lockout_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source handshake: status byte during serial poll, user data otherwise

    logic sh_take;
    logic sh_done;
    logic sh_busy;
    logic sh_dav;
    logic [7:0] sh_data;
    logic sh_eoi;
    logic srq_pend_r;
    logic sent_rqs_r;
    logic sent_sp_r;
    wire sh_active = talk_r && !atn_s && !ifc_s;
    wire [7:0] sp_byte = {i_status[7], srq_pend_r, i_status[5:0]};
    // Skip the sh_done cycle after acceptance, so a repeated status byte already shows the cleared request bit
    wire sh_load = spe_r ? !sh_done : i_tx_valid;
    wire [7:0] sh_in = spe_r ? sp_byte : i_tx_data;
    wire sh_last = spe_r ? 1'b0 : i_tx_last;

    gdi_source u_source (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_active(sh_active),
        .i_load(sh_load),
        .i_data(sh_in),
        .i_last(sh_last),
        .o_take(sh_take),
        .o_done(sh_done),
        .i_nrfd(nrfd_s),
        .i_ndac(ndac_s),
        .o_busy(sh_busy),
        .o_dav_drive(sh_dav),
        .o_data(sh_data),
        .o_eoi(sh_eoi)
    );

    assign o_tx_ready = sh_take && !spe_r;

    ////////////////////////////////////////////////////////////////////////////
    // Service request; a new request in the clearing cycle is kept

    logic srq_req_d_r;
    logic spoll_read_r;
    wire srq_rise = i_srq_req && !srq_req_d_r;
    wire sp_read = sh_done && sent_sp_r;
    wire srq_clear = sp_read && sent_rqs_r;
    wire srq_nxt = srq_rise || (srq_pend_r && !srq_clear);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            srq_req_d_r <= 1'b0;
            srq_pend_r <= 1'b0;
            sent_rqs_r <= 1'b0;
            sent_sp_r <= 1'b0;
            spoll_read_r <= 1'b0;
        end else begin
            srq_req_d_r <= i_srq_req;
            srq_pend_r <= srq_nxt;
            spoll_read_r <= sp_read;
            if (sh_take) begin
                sent_rqs_r <= spe_r && srq_pend_r;
                sent_sp_r <= spe_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Listener data, clear and trigger events

    logic [7:0] rx_data_r;
    logic rx_valid_r;
    logic rx_end_r;
    logic clear_r;
    logic trig_r;
    wire rx_take = ah_stb && !atn_s && listen_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rx_data_r <= 8'h00;
            rx_valid_r <= 1'b0;
            rx_end_r <= 1'b0;
            clear_r <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            rx_valid_r <= rx_take;
            clear_r <= c_dcl || c_sdc;
            trig_r <= c_get;
            if (rx_take) begin
                rx_data_r <= ah_byte;
                rx_end_r <= eoi_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive; ATN, IFC and REN have no drivers at all

    // ATN cuts the data drive at once, so a parallel poll finds the lines free
    wire dio_drive = sh_busy && !atn_s;
    assign o_dio_n = 8'h00;
    assign o_dio_oe_n = ~(sh_data & {8{dio_drive}});
    assign o_dav_n = 1'b0;
    assign o_dav_oe_n = ~(sh_dav && !atn_s);
    assign o_eoi_n = 1'b0;
    assign o_eoi_oe_n = ~(sh_eoi && dio_drive);
    assign o_nrfd_n = 1'b0;
    assign o_nrfd_oe_n = ~ah_nrfd_hold;
    assign o_ndac_n = 1'b0;
    assign o_ndac_oe_n = ~ah_ndac_hold;
    assign o_srq_n = 1'b0;
    assign o_srq_oe_n = ~srq_pend_r;

    assign o_rx_data = rx_data_r;
    assign o_rx_valid = rx_valid_r;
    assign o_rx_end = rx_end_r;
    assign o_srq_pending = srq_pend_r;
    assign o_spoll_read = spoll_read_r;
    assign o_talker = talk_r;
    assign o_listener = listen_r;
    assign o_spoll_mode = spe_r;
    assign o_remote = remote_r;
    assign o_lockout = lockout_r;
    assign o_dev_clear = clear_r;
    assign o_trigger = trig_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_talk_on_mta: assert property (c_mta && !ifc_s |=> talk_r && !listen_r)
        else $error("own talk address did not make talker");
    a_listen_on_mla: assert property (c_mla && !ifc_s |=> listen_r && !talk_r)
        else $error("own listen address did not make listener");
    a_listen_drop: assert property (listen_r && c_mta && !ifc_s |=> !listen_r)
        else $error("own talk address left listener active");
    a_ifc_idles: assert property (ifc_s |=> !talk_r && !listen_r && (&o_dio_oe_n))
        else $error("IFC did not idle talker and listener");
    a_ifc_keeps_rem: assert property (ifc_s && ren_s && !cmd_stb |=> $stable(remote_r))
        else $error("IFC changed remote mode");
    a_no_dio_atn: assert property (atn_s |-> (&o_dio_oe_n) && o_dav_oe_n)
        else $error("data lines driven while ATN asserted");
    a_dav_settled: assert property ($fell(o_dav_oe_n) |-> !$past(nrfd_s) && $past(sh_busy, 2))
        else $error("DAV asserted before settle and ready");
    a_ndac_order: assert property ($fell(ah_ndac_hold) && ah_active |-> ah_nrfd_hold)
        else $error("NDAC released before NRFD held");
    a_rx_listener: assert property (o_rx_valid |-> $past(listen_r) && !$past(atn_s))
        else $error("data accepted while not listener");
    a_foreign_addr: assert property (cmd_stb && !ifc_s && grp != gdi_pkg::GRP_CMD && !own && !is_unl && !is_unt
        |=> $stable(talk_r) && $stable(listen_r) && $stable(remote_r))
        else $error("foreign address changed state");
    a_srq_release: assert property (srq_clear && !srq_rise |=> !srq_pend_r && o_srq_oe_n)
        else $error("SRQ not released after status read");
    a_ren_local: assert property (!ren_s |=> !o_remote && !o_lockout)
        else $error("remote held without REN");
    a_clear_evt: assert property ((c_dcl || c_sdc) |=> o_dev_clear ##1 !o_dev_clear)
        else $error("device clear pulse missing");
    a_trigger_evt: assert property (c_get |=> o_trigger)
        else $error("GET did not trigger");

    c_spoll: cover property (c_spe ##[1:1000] sp_read);
    c_rx_byte: cover property (o_rx_valid && o_rx_end);
    c_trigger: cover property (listen_r && o_trigger);
    c_remote: cover property ($rose(o_remote));

endmodule
`default_nettype wire

// File: gdi_pkg.sv
package gdi_pkg;

    // Clock and source settling time
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 8;
    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYC - 1);

    // Own primary address
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_RESERVED = 5'h1f;

    // Command byte layout: group in bits 6:5, address in bits 4:0
    localparam int GRP_MSB = 6;
    localparam int GRP_LSB = 5;
    localparam logic [1:0] GRP_CMD = 2'h0;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;
    localparam logic [1:0] GRP_SECOND = 2'h3;
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3f;
    localparam logic [6:0] CMD_UNT = 7'h5f;

    // Status byte: request-service bit
    localparam int RQS_BIT = 6;

    // Synchroniser vector positions
    localparam int PIN_W = 15;
    localparam int P_REN = 0;
    localparam int P_IFC = 1;
    localparam int P_EOI = 2;
    localparam int P_ATN = 3;
    localparam int P_NDAC = 4;
    localparam int P_NRFD = 5;
    localparam int P_DAV = 6;
    localparam int P_DIO = 7;

    typedef enum logic [3:0] {
        AH_IDLE = 4'h1,
        AH_WAIT = 4'h2,
        AH_READY = 4'h4,
        AH_TAKEN = 4'h8
    } gdi_ah_state_t;

    typedef enum logic [2:0] {
        SH_IDLE = 3'h1,
        SH_SETTLE = 3'h2,
        SH_ASSERT = 3'h4
    } gdi_sh_state_t;

endpackage

// File: gdi_acceptor.sv
`timescale 1ns/1ps
`default_nettype none
module gdi_acceptor (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_active,
    input wire logic i_ready,
    // Bus, asserted high
    input wire logic i_dav,
    input wire logic [7:0] i_data,
    output logic o_nrfd_hold,
    output logic o_ndac_hold,
    // Accepted byte
    output logic [7:0] o_byte,
    output logic o_byte_stb
);

    gdi_pkg::gdi_ah_state_t state_r;
    gdi_pkg::gdi_ah_state_t state_nxt;
    wire take = (state_r == gdi_pkg::AH_READY) && i_active && i_dav;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            gdi_pkg::AH_IDLE: if (i_active) state_nxt = gdi_pkg::AH_WAIT;
            gdi_pkg::AH_WAIT: begin
                if (!i_active) state_nxt = gdi_pkg::AH_IDLE;
                else if (i_ready && !i_dav) state_nxt = gdi_pkg::AH_READY;
            end
            gdi_pkg::AH_READY: begin
                if (!i_active) state_nxt = gdi_pkg::AH_IDLE;
                else if (i_dav) state_nxt = gdi_pkg::AH_TAKEN;
            end
            // Hold NRFD until the source drops DAV, even if deselected
            gdi_pkg::AH_TAKEN: if (!i_dav) state_nxt = gdi_pkg::AH_WAIT;
            default: state_nxt = gdi_pkg::AH_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= gdi_pkg::AH_IDLE;
            o_byte <= 8'h00;
            o_byte_stb <= 1'b0;
        end else begin
            state_r <= state_nxt;
            o_byte_stb <= take;
            if (take) o_byte <= i_data;
        end
    end

    assign o_nrfd_hold = (state_r == gdi_pkg::AH_WAIT) || (state_r == gdi_pkg::AH_TAKEN);
    assign o_ndac_hold = (state_r == gdi_pkg::AH_WAIT) || (state_r == gdi_pkg::AH_READY);

endmodule
`default_nettype wire

// File: gdi_source.sv
`timescale 1ns/1ps
`default_nettype none
module gdi_source (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Byte to send
    input wire logic i_active,
    input wire logic i_load,
    input wire logic [7:0] i_data,
    input wire logic i_last,
    output logic o_take,
    output logic o_done,
    // Bus, asserted high
    input wire logic i_nrfd,
    input wire logic i_ndac,
    output logic o_busy,
    output logic o_dav_drive,
    output logic [7:0] o_data,
    output logic o_eoi
);

    gdi_pkg::gdi_sh_state_t state_r;
    gdi_pkg::gdi_sh_state_t state_nxt;
    logic [gdi_pkg::SETTLE_W-1:0] cnt_r;
    wire settled = (cnt_r == '0);
    wire accepted = (state_r == gdi_pkg::SH_ASSERT) && i_active && !i_ndac;

    assign o_take = (state_r == gdi_pkg::SH_IDLE) && i_active && i_load;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            gdi_pkg::SH_IDLE: if (o_take) state_nxt = gdi_pkg::SH_SETTLE;
            gdi_pkg::SH_SETTLE: begin
                if (!i_active) state_nxt = gdi_pkg::SH_IDLE;
                else if (settled && !i_nrfd) state_nxt = gdi_pkg::SH_ASSERT;
            end
            gdi_pkg::SH_ASSERT: if (!i_active || !i_ndac) state_nxt = gdi_pkg::SH_IDLE;
            default: state_nxt = gdi_pkg::SH_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= gdi_pkg::SH_IDLE;
            cnt_r <= '0;
            o_data <= 8'h00;
            o_eoi <= 1'b0;
            o_done <= 1'b0;
        end else begin
            state_r <= state_nxt;
            o_done <= accepted;
            if (o_take) begin
                cnt_r <= gdi_pkg::SETTLE_LOAD;
                o_data <= i_data;
                o_eoi <= i_last;
            end else if (!settled) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign o_busy = (state_r != gdi_pkg::SH_IDLE);
    assign o_dav_drive = (state_r == gdi_pkg::SH_ASSERT);

endmodule
`default_nettype wire

// File: gdi_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module gdi_ctrl_model (
    // Clock
    input wire logic i_clk,
    // Bus levels seen, active low
    input wire logic [7:0] i_dio_n,
    input wire logic i_dav_n,
    input wire logic i_nrfd_n,
    input wire logic i_ndac_n,
    // Controller pulls, high pulls the line low; o_to flags a handshake timeout
    output logic [7:0] o_dio,
    output logic o_dav,
    output logic o_nrfd,
    output logic o_ndac,
    output logic o_atn,
    output logic o_ren,
    output logic o_ifc,
    output logic o_to
);
    initial begin
        {o_dio, o_dav, o_nrfd, o_ndac, o_atn, o_ren, o_ifc, o_to} = '0;
    end
    ////////////////////////////////////////////////////////////////
    // Source handshake; ATN held for commands, dropped for data
    task automatic send(input logic [7:0] b, input logic atn);
        int n;
        @(negedge i_clk);
        o_atn = atn;
        {o_nrfd, o_ndac} = 2'b00;
        o_dio = b;
        // Acceptors need a few cycles to see ATN before NRFD means anything
        repeat (4) @(negedge i_clk);
        for (n = 0; n < 400 && i_nrfd_n !== 1'b1; n++) @(negedge i_clk);
        o_to |= (n == 400);
        repeat (3) @(negedge i_clk);
        o_dav = 1'b1;
        for (n = 0; n < 400 && i_ndac_n !== 1'b1; n++) @(negedge i_clk);
        o_to |= (n == 400);
        o_dav = 1'b0;
        o_dio = 8'h00;
        repeat (4) @(negedge i_clk);
    endtask
    // Acceptor; NRFD kept pulled at the end so a repeating talker stalls
    task automatic read(output logic [7:0] b);
        int n;
        @(negedge i_clk);
        {o_atn, o_ndac, o_nrfd} = 3'b010;
        for (n = 0; n < 600 && i_dav_n !== 1'b0; n++) @(negedge i_clk);
        o_to |= (n == 600);
        b = ~i_dio_n;
        {o_nrfd, o_ndac} = 2'b10;
        for (n = 0; n < 400 && i_dav_n !== 1'b1; n++) @(negedge i_clk);
        o_to |= (n == 400);
        o_ndac = 1'b1;
    endtask
    task automatic ren(input logic v);
        @(negedge i_clk);
        o_ren = v;
    endtask
    task automatic ifc_pulse;
        @(negedge i_clk);
        o_ifc = 1'b1;
        repeat (10) @(negedge i_clk);
        o_ifc = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// File: test_gdi_device.sv
`timescale 1ns/1ps
`default_nettype none
module test_gdi_device;
    logic clk = 1'b0, rst = 1'b1, srq_req = 1'b0, tx_valid = 1'b0, tx_last = 1'b0, rx_ready = 1'b1;
    logic tx_taken = 1'b0, eoi_seen = 1'b0;
    logic [7:0] tx_data = 8'h00, rxb, rx_last, rdb, status = 8'h85;
    logic [7:0] d_dio, c_dio, dio_n;
    logic d_dav, d_nrfd, d_ndac, d_eoi, d_srq, c_dav, c_nrfd, c_ndac, c_atn, c_ren, c_ifc, c_to;
    logic tx_ready, rx_valid, srq_pend, talker, listener, spoll, remote, lockout, dclr, trig, rx_end, spr;
    int error_cnt = 0, checked = 0, trig_cnt = 0, clr_cnt = 0, spr_cnt = 0;
    localparam logic [7:0] UNL = {1'b0, gdi_pkg::CMD_UNL}, MTA = 8'h55, MLA = 8'h35, LAG = 8'h2c, TAG = 8'h4c;
    always #5 clk = ~clk;
    // Open-collector wired lines with pull-ups
    assign dio_n = d_dio & ~c_dio;
    gdi_device dut (.i_ref_clk(clk), .i_rst(rst), .i_addr(5'h0c), .i_dio_n(dio_n),
        .i_dav_n(d_dav & ~c_dav), .i_nrfd_n(d_nrfd & ~c_nrfd), .i_ndac_n(d_ndac & ~c_ndac),
        .i_atn_n(~c_atn), .i_eoi_n(d_eoi), .i_ifc_n(~c_ifc), .i_ren_n(~c_ren),
        .o_dio_n(), .o_dio_oe_n(d_dio), .o_dav_n(), .o_dav_oe_n(d_dav), .o_nrfd_n(), .o_nrfd_oe_n(d_nrfd),
        .o_ndac_n(), .o_ndac_oe_n(d_ndac), .o_eoi_n(), .o_eoi_oe_n(d_eoi), .o_srq_n(), .o_srq_oe_n(d_srq),
        .i_tx_data(tx_data), .i_tx_valid(tx_valid && !tx_taken), .i_tx_last(tx_last), .o_tx_ready(tx_ready),
        .o_rx_data(rxb), .o_rx_valid(rx_valid), .o_rx_end(rx_end), .i_rx_ready(rx_ready),
        .i_status(status), .i_srq_req(srq_req), .o_srq_pending(srq_pend), .o_spoll_read(spr),
        .o_talker(talker), .o_listener(listener), .o_spoll_mode(spoll), .o_remote(remote),
        .o_lockout(lockout), .o_dev_clear(dclr), .o_trigger(trig));
    gdi_ctrl_model ctl (.i_clk(clk), .i_dio_n(dio_n), .i_dav_n(d_dav & ~c_dav), .i_nrfd_n(d_nrfd & ~c_nrfd),
        .i_ndac_n(d_ndac & ~c_ndac), .o_dio(c_dio), .o_dav(c_dav), .o_nrfd(c_nrfd), .o_ndac(c_ndac),
        .o_atn(c_atn), .o_ren(c_ren), .o_ifc(c_ifc), .o_to(c_to));
    always @(posedge clk) begin
        trig_cnt <= trig_cnt + int'(trig === 1'b1);
        clr_cnt <= clr_cnt + int'(dclr === 1'b1);
        if (rx_valid === 1'b1) rx_last <= rxb;
        tx_taken <= tx_valid && (tx_taken || tx_ready === 1'b1);
        eoi_seen <= eoi_seen || d_eoi === 1'b0;
        spr_cnt <= spr_cnt + int'(spr === 1'b1);
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t_remote;
        check("dio idle", d_dio, 8'hff);
        ctl.ren(1'b1);
        ctl.send(UNL, 1); ctl.send(MTA, 1); ctl.send(LAG, 1);
        check("listener", listener, 1);
        check("remote", remote, 1);
        check("foreign talk", talker, 0);
        ctl.send(8'h3c, 0);
        check("rx byte", rx_last, 8'h3c);
        check("rx end", rx_end, 0);
    endtask
    task automatic t_local;
        ctl.send(8'h01, 1);
        check("gtl local", remote, 0);
        ctl.send({1'b0, gdi_pkg::CMD_LLO}, 1);
        check("lockout", lockout, 1);
        ctl.ren(1'b0);
        repeat (4) @(negedge clk);
        check("ren off", lockout, 0);
    endtask
    task automatic t_clear;
        ctl.send({1'b0, gdi_pkg::CMD_DCL}, 1);
        ctl.send(UNL, 1); ctl.send(MTA, 1); ctl.send(LAG, 1); ctl.send(8'h04, 1);
        ctl.send(UNL, 1); ctl.send(8'h04, 1);
        check("clears", 8'(clr_cnt), 8'h02);
        ctl.send(8'h08, 1); ctl.send(LAG, 1); ctl.send(8'h08, 1);
        check("triggers", 8'(trig_cnt), 8'h02);
    endtask
    task automatic t_addr;
        ctl.send(TAG, 1);
        check("tag unlisten", {talker, listener}, 8'h02);
        ctl.send(LAG, 1);
        check("lag untalk", {talker, listener}, 8'h01);
        ctl.send(8'h45, 1);
        check("other tag", listener, 1);
    endtask
    task automatic t_spoll;
        @(negedge clk) srq_req = 1'b1;
        repeat (4) @(negedge clk);
        check("srq pulled", d_srq, 0);
        ctl.send(UNL, 1); ctl.send(MLA, 1); ctl.send(TAG, 1); ctl.send({1'b0, gdi_pkg::CMD_SPE}, 1);
        check("spoll mode", spoll, 1);
        ctl.read(rdb);
        check("status", rdb, 8'hc5);
        repeat (3) @(negedge clk);
        check("srq release", {srq_pend, d_srq}, 8'h01);
        check("spoll read", 8'(spr_cnt), 8'h01);
        ctl.send({1'b0, gdi_pkg::CMD_SPD}, 1);
        check("spoll end", spoll, 0);
        tx_data = 8'ha5;
        tx_last = 1'b1;
        tx_valid = 1'b1;
        ctl.read(rdb);
        check("talk byte", rdb, 8'ha5);
        check("talk eoi", eoi_seen, 1);
        ctl.ren(1'b1); ctl.send(LAG, 1); ctl.send(TAG, 1);
        ctl.ifc_pulse;
        check("ifc idle", {talker, listener, remote}, 8'h01);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        t_remote; t_local; t_clear; t_addr; t_spoll;
        check("handshake stall", c_to, 0);
        final_report;
    end
    // Scenarios need well under 10k cycles
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        final_report;
    end
endmodule
`default_nettype wire
